// >>> common/ipc_pkg.sv
// constants, field layouts and carrier types of the interrupt priority controller
// How it works
// - level flag reads current non-maskable pin
// - bit 8 picks falling or rising edge
// - reserved control bits read zero, write zero
// - highest programmed level wins, others stay pending
// - ties resolved by fixed default order
// - accept only above mask; request and pending-low
// - pending low until cleared or masked, ignores block
// - entry only at instruction boundary
// - entry writes cause code to event register
// - entry saves status and program counter
// - entry forces block, privileged, bank bits
// - jump to vector base plus fixed offset
// - entry leaves mask level unchanged
// - block bit holds off entry
// - evaluation delays per source in sub-clocks
// - entry waits for running instruction end
// - five internal cycles from save to fetch
// - encoded level inputs map inversely to level
// - priority field zero masks, fifteen highest
package ipc_pkg;
  localparam int IPC_AW = 5;
  localparam int IPC_DW = 32;
  localparam int IPC_NPER = 14;
  localparam int IPC_NGRP = 7;
  // register addresses
  localparam logic [IPC_AW-1:0] IPC_PRIO_A_ADDR = 5'h00;
  localparam logic [IPC_AW-1:0] IPC_PRIO_B_ADDR = 5'h04;
  localparam logic [IPC_AW-1:0] IPC_ICTL_ADDR = 5'h08;
  localparam logic [IPC_AW-1:0] IPC_EVENT_ADDR = 5'h0C;
  localparam logic [IPC_AW-1:0] IPC_STATUS_ADDR = 5'h10;
  localparam logic [IPC_AW-1:0] IPC_SSTAT_ADDR = 5'h14;
  localparam logic [IPC_AW-1:0] IPC_SPC_ADDR = 5'h18;
  localparam logic [IPC_AW-1:0] IPC_VBR_ADDR = 5'h1C;
  // interrupt control fields
  localparam int IPC_ICTL_LEVEL_BIT = 15;
  localparam int IPC_ICTL_EDGE_BIT = 8;
  // status fields
  localparam int IPC_ST_MD_BIT = 30;
  localparam int IPC_ST_RB_BIT = 29;
  localparam int IPC_ST_BL_BIT = 28;
  localparam int IPC_ST_MASK_LSB = 4;
  localparam logic [31:0] IPC_STATUS_RESET = 32'h700000F0;
  // codes and levels
  localparam logic [11:0] IPC_NMI_CODE = 12'h1C0;
  localparam logic [11:0] IPC_LVL_CODE_BASE = 12'h200;
  localparam logic [11:0] IPC_PER_CODE_BASE = 12'h400;
  localparam logic [11:0] IPC_CODE_STEP = 12'h020;
  localparam logic [4:0] IPC_NMI_LEVEL = 5'h10;
  localparam logic [3:0] IPC_LVL_NONE = 4'hF;
  localparam logic [31:0] IPC_VEC_OFFSET = 32'h00000600;
  localparam int IPC_ENTRY_ICYC = 5;
  // priority field owning each peripheral cause, in default order
  localparam logic [2:0] IPC_GRP_OF [IPC_NPER] =
    '{3'h0, 3'h1, 3'h2, 3'h2, 3'h3, 3'h3, 3'h3, 3'h4, 3'h4, 3'h4, 3'h4, 3'h5, 3'h6, 3'h6};
  // field low bit within {b, a}
  localparam logic [4:0] IPC_GRP_LSB [IPC_NGRP] =
    '{5'h0C, 5'h08, 5'h04, 5'h00, 5'h14, 5'h1C, 5'h18};
  typedef enum logic [1:0] {IPC_IDLE = 2'b00, IPC_SAVE = 2'b01, IPC_WAIT = 2'b11} ipc_state_t;
  typedef struct packed {
    logic valid;
    logic [4:0] level;
    logic [11:0] code;
  } ipc_req_t;
endpackage

// >>> rtl/ipc_top.sv
// interrupt priority controller with exception-entry sequencer
//
// Decided for this implementation: strobed register access and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module ipc_top import ipc_pkg::*; #(
  parameter int PCLK_DIV = 4,
  parameter int BCLK_DIV = 1
) (
  // clock and reset
  input wire logic SYS_CLK,
  input wire logic ARST_N,
  // register port
  input wire logic [IPC_AW-1:0] REG_ADDR,
  input wire logic [IPC_DW-1:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [IPC_DW-1:0] REG_RDATA,
  // request sources
  input wire logic NMI_PIN,
  input wire logic [3:0] ENCODED_LEVEL_INPUTS,
  input wire logic [IPC_NPER-1:0] PERIPH_REQ,
  // cpu side
  input wire logic INSN_BOUNDARY,
  input wire logic [31:0] CPU_PC,
  output logic CPU_IRQ,
  output logic ENTRY_PULSE,
  output logic FETCH_START,
  output logic [31:0] FETCH_ADDR,
  // pin
  output logic PENDING_REQUEST_OUT_N
);
  ipc_state_t state_reg, state_next;
  logic [15:0] prio_a_reg, prio_b_reg;
  logic edge_sel_reg;
  logic [11:0] event_code_reg;
  logic [31:0] status_reg, saved_status_reg, saved_pc_reg, vector_base_reg;
  logic [31:0] rdata_reg;
  logic [7:0] pdiv_reg, bdiv_reg;
  logic nmi_s1, nmi_s2, nmi_p, nmi_pend_reg;
  logic [3:0] lvl_s1, lvl_s2, lvl_prev, lvl_ok;
  logic [IPC_NPER-1:0] per_q;
  logic [2:0] cnt_reg;
  ipc_req_t acc_reg;
  logic fetch_reg;
  logic [31:0] fetch_addr_reg;

  // clock enables
  wire p_tick = (pdiv_reg == 8'(PCLK_DIV - 1));
  wire b_tick = (bdiv_reg == 8'(BCLK_DIV - 1));
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      pdiv_reg <= 8'h00;
      bdiv_reg <= 8'h00;
    end else begin
      pdiv_reg <= p_tick ? 8'h00 : pdiv_reg + 8'h01;
      bdiv_reg <= b_tick ? 8'h00 : bdiv_reg + 8'h01;
    end
  end

  // non-maskable input: synchroniser, then edge sampled per peripheral cycle
  wire nmi_edge = p_tick && (edge_sel_reg ? (nmi_s2 && !nmi_p) : (!nmi_s2 && nmi_p));
  wire st_bl = status_reg[IPC_ST_BL_BIT];
  wire [3:0] st_mask = status_reg[IPC_ST_MASK_LSB +: 4];
  // mask rechecked here: a status write may raise it while the old accept is still held
  wire enter = (state_reg == IPC_IDLE) && acc_reg.valid
    && (acc_reg.level > {1'b0, st_mask}) && !st_bl && INSN_BOUNDARY;
  wire nmi_taken = enter && (acc_reg.code == IPC_NMI_CODE);
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      nmi_s1 <= 1'b0;
      nmi_s2 <= 1'b0;
      nmi_p <= 1'b0;
      nmi_pend_reg <= 1'b0;
    end else begin
      nmi_s1 <= NMI_PIN;
      nmi_s2 <= nmi_s1;
      if (p_tick) nmi_p <= nmi_s2;
      // a new edge wins over the clear at entry
      if (nmi_edge) nmi_pend_reg <= 1'b1;
      else if (nmi_taken) nmi_pend_reg <= 1'b0;
    end
  end

  // level inputs: taken only after two equal peripheral samples (noise filter)
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      lvl_s1 <= IPC_LVL_NONE;
      lvl_s2 <= IPC_LVL_NONE;
      lvl_prev <= IPC_LVL_NONE;
      lvl_ok <= IPC_LVL_NONE;
      per_q <= '0;
    end else begin
      lvl_s1 <= ENCODED_LEVEL_INPUTS;
      lvl_s2 <= lvl_s1;
      if (p_tick) begin
        lvl_prev <= lvl_s2;
        if (lvl_s2 == lvl_prev) lvl_ok <= lvl_s2;
        per_q <= PERIPH_REQ;
      end
    end
  end

  // selection: strictly greater level replaces, so ties keep the earlier source
  function automatic ipc_req_t pick(input logic nmi, input logic [3:0] lvl,
                                    input logic [IPC_NPER-1:0] per,
                                    input logic [15:0] pa, input logic [15:0] pb);
    ipc_req_t best;
    logic [31:0] ab;
    logic [3:0] f;
    best = '0;
    ab = {pb, pa};
    f = 4'h0;
    if (nmi) begin
      best = '{valid: 1'b1, level: IPC_NMI_LEVEL, code: IPC_NMI_CODE};
    end
    if (lvl != IPC_LVL_NONE && {1'b0, ~lvl} > best.level) begin
      best = '{valid: 1'b1, level: {1'b0, ~lvl},
               code: IPC_LVL_CODE_BASE + 12'(lvl) * IPC_CODE_STEP};
    end
    for (int i = 0; i < IPC_NPER; i++) begin
      f = ab[IPC_GRP_LSB[IPC_GRP_OF[i]] +: 4];
      // level zero masks the source
      if (per[i] && f != 4'h0 && {1'b0, f} > best.level) begin
        best = '{valid: 1'b1, level: {1'b0, f}, code: IPC_PER_CODE_BASE + 12'(i) * IPC_CODE_STEP};
      end
    end
    return best;
  endfunction

  wire ipc_req_t sel = pick(nmi_pend_reg, lvl_ok, per_q, prio_a_reg, prio_b_reg);
  wire above_mask = sel.valid && (sel.level > {1'b0, st_mask});

  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) acc_reg <= '0;
    else acc_reg <= above_mask ? sel : '0;
  end
  assign CPU_IRQ = acc_reg.valid;
  assign PENDING_REQUEST_OUT_N = !acc_reg.valid;

  // entry sequencer
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      IPC_IDLE: begin
        if (enter) state_next = IPC_SAVE;
      end
      IPC_SAVE: begin
        state_next = IPC_WAIT;
      end
      IPC_WAIT: begin
        if (cnt_reg == 3'(IPC_ENTRY_ICYC - 1)) state_next = IPC_IDLE;
      end
      default: state_next = IPC_IDLE;
    endcase
  end

  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      state_reg <= IPC_IDLE;
      cnt_reg <= 3'h0;
      fetch_reg <= 1'b0;
      fetch_addr_reg <= '0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= (state_reg == IPC_IDLE) ? 3'h0 : cnt_reg + 3'h1;
      fetch_reg <= (state_reg == IPC_WAIT) && (state_next == IPC_IDLE);
      if (enter) fetch_addr_reg <= vector_base_reg + IPC_VEC_OFFSET;
    end
  end
  assign ENTRY_PULSE = (state_reg == IPC_SAVE);
  assign FETCH_START = fetch_reg;
  assign FETCH_ADDR = fetch_addr_reg;

  // register writes; entry overrides a coincident status write
  wire wr_pa = REG_WR && (REG_ADDR == IPC_PRIO_A_ADDR);
  wire wr_pb = REG_WR && (REG_ADDR == IPC_PRIO_B_ADDR);
  wire wr_ic = REG_WR && (REG_ADDR == IPC_ICTL_ADDR);
  wire wr_st = REG_WR && (REG_ADDR == IPC_STATUS_ADDR);
  wire wr_ss = REG_WR && (REG_ADDR == IPC_SSTAT_ADDR);
  wire wr_sp = REG_WR && (REG_ADDR == IPC_SPC_ADDR);
  wire wr_vb = REG_WR && (REG_ADDR == IPC_VBR_ADDR);
  wire [31:0] forced = (32'h1 << IPC_ST_BL_BIT) | (32'h1 << IPC_ST_MD_BIT)
                     | (32'h1 << IPC_ST_RB_BIT);
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      prio_a_reg <= 16'h0000;
      prio_b_reg <= 16'h0000;
      edge_sel_reg <= 1'b0;
      event_code_reg <= 12'h000;
      status_reg <= IPC_STATUS_RESET;
      saved_status_reg <= 32'h00000000;
      saved_pc_reg <= 32'h00000000;
      vector_base_reg <= 32'h00000000;
    end else begin
      if (wr_pa) prio_a_reg <= REG_WDATA[15:0];
      if (wr_pb) prio_b_reg <= {REG_WDATA[15:4], 4'h0};
      if (wr_ic) edge_sel_reg <= REG_WDATA[IPC_ICTL_EDGE_BIT];
      if (wr_vb) vector_base_reg <= REG_WDATA;
      if (enter) begin
        event_code_reg <= acc_reg.code;
        saved_status_reg <= status_reg;
        saved_pc_reg <= CPU_PC;
        status_reg <= status_reg | forced;
      end else begin
        if (wr_st) status_reg <= REG_WDATA;
        if (wr_ss) saved_status_reg <= REG_WDATA;
        if (wr_sp) saved_pc_reg <= REG_WDATA;
      end
    end
  end

  // read port: data in the cycle after the strobe, zero elsewhere
  wire [15:0] ictl_rd = 16'((32'(nmi_s2) << IPC_ICTL_LEVEL_BIT)
                      | (32'(edge_sel_reg) << IPC_ICTL_EDGE_BIT));
  wire [31:0] rd_mux =
    (REG_ADDR == IPC_PRIO_A_ADDR) ? {16'h0000, prio_a_reg} :
    (REG_ADDR == IPC_PRIO_B_ADDR) ? {16'h0000, prio_b_reg} :
    (REG_ADDR == IPC_ICTL_ADDR) ? {16'h0000, ictl_rd} :
    (REG_ADDR == IPC_EVENT_ADDR) ? {20'h00000, event_code_reg} :
    (REG_ADDR == IPC_STATUS_ADDR) ? status_reg :
    (REG_ADDR == IPC_SSTAT_ADDR) ? saved_status_reg :
    (REG_ADDR == IPC_SPC_ADDR) ? saved_pc_reg :
    (REG_ADDR == IPC_VBR_ADDR) ? vector_base_reg : 32'h00000000;
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) rdata_reg <= 32'h00000000;
    else rdata_reg <= REG_RD ? rd_mux : 32'h00000000;
  end
  assign REG_RDATA = rdata_reg;

  // checks
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!ARST_N);
  sequence entry_seq;
    enter ##1 ENTRY_PULSE;
  endsequence
  level_flag_a: assert property (REG_RD && REG_ADDR == IPC_ICTL_ADDR |=>
    REG_RDATA[IPC_ICTL_LEVEL_BIT] == $past(nmi_s2)) else $error("level flag wrong");
  edge_pend_a: assert property (nmi_edge |=> nmi_pend_reg) else $error("edge lost");
  ctl_resv_a: assert property (REG_RD && REG_ADDR == IPC_ICTL_ADDR |=>
    (REG_RDATA & 32'hFFFF7EFF) == 32'h0) else $error("reserved bits set");
  accept_a: assert property (above_mask |=> CPU_IRQ && !PENDING_REQUEST_OUT_N)
    else $error("accept missing");
  masked_a: assert property (!above_mask |=> PENDING_REQUEST_OUT_N)
    else $error("pending not released");
  block_hold_a: assert property (st_bl && state_reg == IPC_IDLE |=> !ENTRY_PULSE)
    else $error("entry while blocked");
  boundary_a: assert property (ENTRY_PULSE |-> $past(INSN_BOUNDARY))
    else $error("entry off boundary");
  code_save_a: assert property (enter |=> event_code_reg == $past(acc_reg.code)
    && saved_pc_reg == $past(CPU_PC)) else $error("cause not saved");
  forced_bits_a: assert property (entry_seq |-> (status_reg & forced) == forced
    && status_reg[IPC_ST_MASK_LSB +: 4] == $past(st_mask)) else $error("status wrong");
  fetch_time_a: assert property (entry_seq |-> !FETCH_START [*5] ##1 FETCH_START
    && FETCH_ADDR == vector_base_reg + IPC_VEC_OFFSET) else $error("fetch timing");
endmodule // ipc_top
`default_nettype wire

// >>> dv/ipc_cpu_model.sv
// cpu core model: instruction boundaries and program counter
`timescale 1ns/1ps
`default_nettype none
module ipc_cpu_model (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // control
  input wire logic slow,
  // core side
  output logic boundary,
  output logic [31:0] pc
);
  logic [1:0] cnt_reg;
  // slow mode runs four-cycle instructions, so entry must wait for the end
  assign boundary = (cnt_reg == 2'h0);
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_reg <= 2'h0;
      pc <= 32'h00000000;
    end else begin
      cnt_reg <= (cnt_reg == 2'h0) ? (slow ? 2'h3 : 2'h0) : cnt_reg - 2'h1;
      if (cnt_reg == 2'h0) begin
        pc <= pc + 32'h00000002;
      end
    end
  end
endmodule // ipc_cpu_model
`default_nettype wire

// >>> dv/interrupt_priority_controller_tb.sv
// testbench of the interrupt priority controller
`timescale 1ns/1ps
`default_nettype none
module interrupt_priority_controller_tb;
  import ipc_pkg::*;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [IPC_AW-1:0] addr = '0;
  logic [IPC_DW-1:0] wdata = '0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic nmi = 1'b1;
  logic [3:0] lvl = 4'hF;
  logic [IPC_NPER-1:0] preq = '0;
  logic slow = 1'b0;
  logic [IPC_DW-1:0] rdata;
  logic [31:0] pc;
  logic [31:0] faddr;
  logic bnd;
  logic irq;
  logic entry;
  logic fetch;
  logic pend_n;
  int miscompares = 0;
  int n_tests = 0;
  always #4 clk = ~clk;
  ipc_top ipc_top_inst (.SYS_CLK(clk), .ARST_N(arst_n), .REG_ADDR(addr), .REG_WDATA(wdata),
    .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata), .NMI_PIN(nmi), .ENCODED_LEVEL_INPUTS(lvl),
    .PERIPH_REQ(preq), .INSN_BOUNDARY(bnd), .CPU_PC(pc), .CPU_IRQ(irq), .ENTRY_PULSE(entry),
    .FETCH_START(fetch), .FETCH_ADDR(faddr), .PENDING_REQUEST_OUT_N(pend_n));
  ipc_cpu_model ipc_cpu_model_inst (.clk(clk), .arst_n(arst_n), .slow(slow), .boundary(bnd),
    .pc(pc));
  task automatic results;
    if (miscompares == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wreg(input logic [IPC_AW-1:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rchk(input logic [IPC_AW-1:0] a, input logic [31:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk(rdata, e);
    @(posedge clk);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wait_pend(input logic v);
    int i;
    for (i = 0; i < 100 && pend_n !== v; i++) @(negedge clk);
    chk({31'h0, pend_n}, {31'h0, v});
    if (pend_n !== v) results();
  endtask
  // unblocks, waits for entry, then checks fetch timing and address, cause code, saved status and forced status bits
  task automatic go(input logic [11:0] code, input logic [31:0] st);
    int i;
    wreg(IPC_STATUS_ADDR, st);
    for (i = 0; i < 200 && entry !== 1'b1; i++) @(negedge clk);
    if (entry !== 1'b1) begin
      miscompares++;
      results();
    end
    for (i = 0; i < 20 && fetch !== 1'b1; i++) @(negedge clk);
    chk(i, 32'(IPC_ENTRY_ICYC));
    if (fetch !== 1'b1) results();
    chk(faddr, 32'h00001000 + IPC_VEC_OFFSET);
    rchk(IPC_EVENT_ADDR, {20'h0, code});
    rchk(IPC_SSTAT_ADDR, st);
    rchk(IPC_STATUS_ADDR, st | (32'h1 << IPC_ST_BL_BIT) | (32'h1 << IPC_ST_MD_BIT)
      | (32'h1 << IPC_ST_RB_BIT));
  endtask
  initial begin
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    rchk(IPC_STATUS_ADDR, IPC_STATUS_RESET);
    rchk(IPC_ICTL_ADDR, 32'h00008000);
    wreg(IPC_ICTL_ADDR, 32'h00000100);
    rchk(IPC_ICTL_ADDR, 32'h00008100);
    rchk(5'h02, 32'h00000000);
    wreg(IPC_VBR_ADDR, 32'h00001000);
    wreg(IPC_PRIO_A_ADDR, 32'h00003500);
    preq <= 14'h0003;
    go(12'h420, 32'h60000000);
    preq <= 14'h0001;
    // let the dropped cause clear before unblocking
    idle(12);
    go(12'h400, 32'h60000000);
    wreg(IPC_PRIO_A_ADDR, 32'h00000050);
    preq <= 14'h000C;
    go(12'h440, 32'h60000000);
    preq <= 14'h0000;
    idle(12);
    wreg(IPC_PRIO_A_ADDR, 32'h00005000);
    preq <= 14'h0001;
    wreg(IPC_STATUS_ADDR, 32'h70000050);
    idle(20);
    chk({30'h0, pend_n, irq}, 32'h00000002);
    wreg(IPC_PRIO_A_ADDR, 32'h00006000);
    wait_pend(1'b0);
    idle(20);
    chk({30'h0, pend_n, irq}, 32'h00000001);
    rchk(IPC_STATUS_ADDR, 32'h70000050);
    wreg(IPC_STATUS_ADDR, 32'h700000F0);
    wait_pend(1'b1);
    wreg(IPC_PRIO_A_ADDR, 32'h00000000);
    wreg(IPC_STATUS_ADDR, 32'h60000000);
    idle(20);
    chk({31'h0, pend_n}, 32'h00000001);
    preq <= 14'h0000;
    lvl <= 4'h3;
    go(12'h260, 32'h60000000);
    // nested handler: unblock with the mask raised to the accepted level
    wreg(IPC_STATUS_ADDR, 32'h600000C0);
    idle(20);
    chk({30'h0, pend_n, irq}, 32'h00000002);
    wreg(IPC_PRIO_A_ADDR, 32'h0000D000);
    preq <= 14'h0001;
    go(12'h400, 32'h600000C0);
    preq <= 14'h0000;
    lvl <= 4'hF;
    idle(12);
    slow <= 1'b1;
    wreg(IPC_ICTL_ADDR, 32'h00000000);
    nmi <= 1'b0;
    go(IPC_NMI_CODE, 32'h60000000);
    rchk(IPC_ICTL_ADDR, 32'h00000000);
    results();
  end
endmodule // interrupt_priority_controller_tb
`default_nettype wire
